// ### rsc_defs.svh
// Constants for the receive output strap control block: offsets, fields,
// reset values and timing counts.
// Assumes inclusion by bare name from the block's package and modules.
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ==========================================================
// Register offsets (word index on the plain register port)
`define RSC_ADDR_W          4
`define RSC_OFS_CH_CFG0     4'h0
`define RSC_OFS_STATUS      4'h8
`define RSC_OFS_MODE        4'h9

// ==========================================================
// Field positions
`define RSC_CFG_RES_LSB     0
`define RSC_CFG_RES_MSB     1
`define RSC_CFG_MUTE_BIT    2
`define RSC_MODE_EDGE_BIT   0
`define RSC_MODE_BUS_LSB    1
`define RSC_MODE_UFLOW_BIT  3

// ==========================================================
// Reset values
`define RSC_CFG_RST         3'h4
`define RSC_MODE_EDGE_RST   1'h0

// ==========================================================
// Sizes and timing
`define RSC_CHANNELS        8
`define RSC_FIFO_DEPTH      16
`define RSC_CORE_CLK_HZ     40000000
`define RSC_LOS_MIN_RCLK    1

`endif

// ### rsc_pkg.sv
// Types shared by the receive output strap control block.
// Assumes rsc_defs.svh is on the include path.
`default_nettype none
`include "rsc_defs.svh"

package rsc_pkg;

   // ==========================================================
   // External receive resistor selection
   typedef enum logic [1:0] {
      RSC_RES_NONE,
      RSC_RES_240,
      RSC_RES_210,
      RSC_RES_150
   } rsc_res_sel_t;

   // ==========================================================
   // Host bus style selected by the shared straps in host mode
   typedef enum logic [1:0] {
      RSC_BUS_ASYNC_A,
      RSC_BUS_ASYNC_B,
      RSC_BUS_RSVD_2,
      RSC_BUS_RSVD_3
   } rsc_bus_type_t;

   // ==========================================================
   // Decoding used for every channel and for read-back
   function automatic logic rsc_res_present(input logic [1:0] sel);
      return (rsc_res_sel_t'(sel) != RSC_RES_NONE);
   endfunction : rsc_res_present

endpackage : rsc_pkg

`default_nettype wire

// ### rsc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module rsc_fifo
   import rsc_pkg::*;
#(
   parameter int W     = 16,
   parameter int DEPTH = `RSC_FIFO_DEPTH
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rstn,
   input  wire logic         i_in_valid,
   output var  logic         o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output var  logic         o_out_valid,
   input  wire logic         i_out_ready,
   output var  logic [W-1:0] o_out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wr_ptr;
      logic [AW-1:0]           rd_ptr;
      logic [AW:0]             count;
      logic                    ready;
   } rsc_fifo_st_t;

   rsc_fifo_st_t q, d;
   logic         push;
   logic         pop;

   // ==========================================================
   // Next state
   always_comb begin
      d    = q;
      push = i_in_valid & q.ready;
      pop  = i_out_ready & (q.count != '0);
      if (push) begin
         d.mem[q.wr_ptr] = i_in_data;
         d.wr_ptr        = q.wr_ptr + AW'(1);
      end
      if (pop) begin
         d.rd_ptr = q.rd_ptr + AW'(1);
      end
      d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
      // Ready is registered so the source sees no combinational path
      d.ready = (d.count != (AW+1)'(DEPTH));
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         q       <= '0;
         q.ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_in_ready  = q.ready;
   assign o_out_valid = (q.count != '0);
   assign o_out_data  = q.mem[q.rd_ptr];

endmodule : rsc_fifo

`default_nettype wire

// ### rsc_rx_output_ctrl.sv
// Receive output strap control: muting on loss of signal, update-edge
// choice, resistor selection and host bus type decoding for all channels.
// Assumes all inputs, the recovered clock among them, are synchronous to
// i_core_clk, which runs far faster than the recovered clock.
`timescale 1ns/10ps
`default_nettype none

module rsc_rx_output_ctrl
   import rsc_pkg::*;
#(
   parameter int N_CH       = `RSC_CHANNELS,
   parameter int FIFO_DEPTH = `RSC_FIFO_DEPTH
) (
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rstn,
   input  wire logic                   i_host_mode,
   input  wire logic                   i_los_mute_strap,
   input  wire logic                   i_rx_update_edge_select,
   input  wire logic                   i_tx_edge_strap,
   input  wire logic [1:0]             i_ext_resistor_select,
   input  wire logic [1:0]             i_termination_select,
   input  wire logic                   i_rec_clk,
   input  wire logic [N_CH-1:0]        i_loss_detect,
   input  wire logic                   i_rx_valid,
   output var  logic                   o_rx_ready,
   input  wire logic [N_CH-1:0]        i_rx_pos_data,
   input  wire logic [N_CH-1:0]        i_rx_neg_data,
   output var  logic [N_CH-1:0]        o_rx_pos_rail_out,
   output var  logic [N_CH-1:0]        o_rx_neg_rail_out,
   output var  logic [N_CH-1:0]        o_loss_of_signal_flag,
   output var  logic [2*N_CH-1:0]      o_ext_resistor_select,
   output var  logic [N_CH-1:0]        o_int_impedance_adjust,
   output var  logic [2*N_CH-1:0]      o_termination_select,
   output var  logic [1:0]             o_host_bus_type_select,
   input  wire logic [`RSC_ADDR_W-1:0] i_addr,
   input  wire logic [7:0]             i_wr_data,
   input  wire logic                   i_wr_en,
   input  wire logic                   i_rd_en,
   output var  logic [7:0]             o_rd_data
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [N_CH-1:0][2:0]   cfg;
      logic                   edge_cfg;
      logic                   uflow;
      logic                   clk_prev;
      logic [N_CH-1:0]        pos;
      logic [N_CH-1:0]        neg;
      logic [N_CH-1:0]        los;
      logic [N_CH-1:0]        los_held;
      logic [2*N_CH-1:0]      res;
      logic [N_CH-1:0]        int_adj;
      logic [2*N_CH-1:0]      term;
      logic [1:0]             bus_type;
      logic [7:0]             rd_data;
   } rsc_st_t;

   rsc_st_t           q, d;
   logic              fifo_valid;
   logic              fifo_pop;
   logic [2*N_CH-1:0] fifo_data;
   logic [N_CH-1:0]   mute_vec;
   logic              rise;
   logic              fall;
   logic              upd;

   // ==========================================================
   // Receive data buffer between recovery and the rail outputs
   rsc_fifo #(
      .W     (2*N_CH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk  (i_core_clk),
      .i_rstn      (i_rstn),
      .i_in_valid  (i_rx_valid),
      .o_in_ready  (o_rx_ready),
      .i_in_data   ({i_rx_neg_data, i_rx_pos_data}),
      .o_out_valid (fifo_valid),
      .i_out_ready (fifo_pop),
      .o_out_data  (fifo_data)
   );

   // ==========================================================
   // Next state
   always_comb begin
      logic       edge_sel;
      logic       mute_en;
      logic [1:0] sel;
      edge_sel = 1'b0;
      mute_en  = 1'b0;
      sel      = 2'h0;
      d        = q;
      mute_vec = '0;
      d.clk_prev = i_rec_clk;
      rise = i_rec_clk & ~q.clk_prev;
      fall = ~i_rec_clk & q.clk_prev;
      edge_sel = i_host_mode ? q.edge_cfg : i_rx_update_edge_select;
      upd      = edge_sel ? fall : rise;
      fifo_pop = upd;
      // Missing data at an update edge is flagged; rails hold old data
      if (upd && !fifo_valid) begin
         d.uflow = 1'b1;
      end

      for (int ch = 0; ch < N_CH; ch++) begin
         // Loss flag: set at once, cleared only after a rising edge
         if (!q.los[ch]) begin
            if (i_loss_detect[ch]) begin
               d.los[ch]      = 1'b1;
               d.los_held[ch] = 1'b0;
            end
         end else begin
            if (rise) begin
               d.los_held[ch] = 1'b1;
            end
            if (!i_loss_detect[ch] && (q.los_held[ch] || rise)) begin
               d.los[ch] = 1'b0;
            end
         end

         mute_en = i_host_mode ? q.cfg[ch][`RSC_CFG_MUTE_BIT] : i_los_mute_strap;
         mute_vec[ch] = mute_en & q.los[ch];
         if (mute_vec[ch]) begin
            d.pos[ch] = 1'b0;
            d.neg[ch] = 1'b0;
         end else if (upd && fifo_valid) begin
            d.pos[ch] = fifo_data[ch];
            d.neg[ch] = fifo_data[N_CH+ch];
         end

         // Strap pins in hardware mode, per-channel register in host mode
         sel = i_host_mode ? q.cfg[ch][`RSC_CFG_RES_MSB:`RSC_CFG_RES_LSB]
                           : i_ext_resistor_select;
         d.res[2*ch +: 2] = sel;
         // Internal impedance trims only when a fixed resistor shares the line
         d.int_adj[ch]     = rsc_res_present(sel);
         d.term[2*ch +: 2] = i_termination_select;
      end

      // Shared straps carry the bus style only in host mode
      d.bus_type = i_host_mode ? {i_tx_edge_strap, i_rx_update_edge_select}
                               : 2'h0;

      // Register port
      d.rd_data = 8'h00;
      if (i_rd_en) begin
         if (i_addr < `RSC_ADDR_W'(N_CH)) begin
            d.rd_data = {3'h0, rsc_res_present(q.cfg[i_addr[2:0]][1:0]),
                         1'b0, q.cfg[i_addr[2:0]]};
         end else if (i_addr == `RSC_OFS_STATUS) begin
            d.rd_data = 8'(q.los);
         end else if (i_addr == `RSC_OFS_MODE) begin
            d.rd_data = {4'h0, q.uflow, q.bus_type, q.edge_cfg};
         end
      end
      if (i_wr_en) begin
         if (i_addr < `RSC_ADDR_W'(N_CH)) begin
            d.cfg[i_addr[2:0]] = i_wr_data[2:0];
         end else if (i_addr == `RSC_OFS_MODE) begin
            d.edge_cfg = i_wr_data[`RSC_MODE_EDGE_BIT];
            // Clearing by writing one; a new underflow in the same cycle wins
            if (i_wr_data[`RSC_MODE_UFLOW_BIT] && !(upd && !fifo_valid)) begin
               d.uflow = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         q          <= '0;
         q.cfg      <= {N_CH{`RSC_CFG_RST}};
         q.edge_cfg <= `RSC_MODE_EDGE_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign o_rx_pos_rail_out      = q.pos;
   assign o_rx_neg_rail_out      = q.neg;
   assign o_loss_of_signal_flag  = q.los;
   assign o_ext_resistor_select  = q.res;
   assign o_int_impedance_adjust = q.int_adj;
   assign o_termination_select   = q.term;
   assign o_host_bus_type_select = q.bus_type;
   assign o_rd_data              = q.rd_data;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rstn);

   property p_mute_low;
      (mute_vec != '0) |=> ((o_rx_pos_rail_out & $past(mute_vec)) == '0)
                       && ((o_rx_neg_rail_out & $past(mute_vec)) == '0);
   endproperty
   a_mute_low: assert property (p_mute_low) else $error("muted rail not low");

   property p_mute_per_channel;
      !i_host_mode |-> (mute_vec == ({N_CH{i_los_mute_strap}} & o_loss_of_signal_flag));
   endproperty
   a_mute_per_channel: assert property (p_mute_per_channel) else $error("mute not per channel");

   property p_unmuted_pass;
      (!i_host_mode && !i_los_mute_strap && upd && fifo_valid)
         |=> (o_rx_pos_rail_out == $past(fifo_data[N_CH-1:0]));
   endproperty
   a_unmuted_pass: assert property (p_unmuted_pass) else $error("data muted with strap low");

   property p_hw_res;
      !i_host_mode |=> (o_ext_resistor_select[1:0] == $past(i_ext_resistor_select))
                    && (o_int_impedance_adjust[0] == ($past(i_ext_resistor_select) != 2'h0));
   endproperty
   a_hw_res: assert property (p_hw_res) else $error("strap resistor decode wrong");

   property p_host_res;
      i_host_mode |=> (o_ext_resistor_select[1:0] == $past(q.cfg[0][1:0]));
   endproperty
   a_host_res: assert property (p_host_res) else $error("host resistor not from register");

   property p_rise_edge;
      (!i_host_mode && !i_rx_update_edge_select && !i_rec_clk && q.clk_prev) |-> !fifo_pop;
   endproperty
   a_rise_edge: assert property (p_rise_edge) else $error("update on falling edge");

   property p_fall_edge;
      (!i_host_mode && i_rx_update_edge_select && i_rec_clk && !q.clk_prev) |-> !fifo_pop;
   endproperty
   a_fall_edge: assert property (p_fall_edge) else $error("update on rising edge");

   property p_bus_type;
      i_host_mode |=> (o_host_bus_type_select == $past({i_tx_edge_strap, i_rx_update_edge_select}));
   endproperty
   a_bus_type: assert property (p_bus_type) else $error("bus type not from straps");

   property p_los_hold;
      (o_loss_of_signal_flag[0] && (i_loss_detect[0] || !q.los_held[0])
         && !(i_rec_clk && !q.clk_prev)) |=> o_loss_of_signal_flag[0];
   endproperty
   a_los_hold: assert property (p_los_hold) else $error("loss flag dropped early");

   property p_resume;
      (!i_host_mode && i_los_mute_strap && !o_loss_of_signal_flag[0] && upd && fifo_valid)
         |=> (o_rx_pos_rail_out[0] == $past(fifo_data[0]));
   endproperty
   a_resume: assert property (p_resume) else $error("data not resumed after loss");

   property p_status_read;
      (i_rd_en && i_addr == `RSC_OFS_STATUS) |=> (o_rd_data == 8'($past(o_loss_of_signal_flag)));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

endmodule : rsc_rx_output_ctrl

`default_nettype wire

// ### rsc_framer_model.sv
// Framer-side model that samples the receive rails and drives the mute strap.
// Assumes the recovered clock is slow against i_core_clk and seen as data.
`timescale 1ns/10ps
`default_nettype none

module rsc_framer_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_rec_clk,
   input  wire logic        i_edge_sel,
   input  wire logic        i_mute_en,
   input  wire logic [7:0]  i_pos,
   input  wire logic [7:0]  i_neg,
   output var  logic        o_los_mute_strap,
   output var  logic [15:0] o_cap
);
   logic rec_q;

   // ==========================================================
   // Strap is pulled low by this side to switch muting off
   assign o_los_mute_strap = i_mute_en;

   // ==========================================================
   // Capture on the edge opposite the update edge, mid-bit, so rails are settled
   always_ff @(posedge i_core_clk) begin
      rec_q <= i_rec_clk;
      if (rec_q != i_rec_clk && i_rec_clk == i_edge_sel) begin
         o_cap <= {i_neg, i_pos};
      end
   end
endmodule : rsc_framer_model

`default_nettype wire

// ### rx_output_strap_control_tb_top.sv
// Self-checking bench for the receive output strap control block.
// Assumes the framer model file is compiled first.
`timescale 1ns/10ps
`default_nettype none

module rx_output_strap_control_tb_top;
   import rsc_pkg::*;
   logic        i_core_clk, i_rstn, host, mute_en, edge_sel, tx_edge, rec, valid, wr, rd;
   logic [1:0]  res, term;
   logic [7:0]  loss, pos, neg, wdata, rdata, flag, imp, rp, rn;
   logic [3:0]  addr;
   logic        ready, strap;
   logic [15:0] ext, tsel, cap;
   logic [1:0]  bus;
   int          error_cnt, checks;

   rsc_rx_output_ctrl dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_host_mode(host),
      .i_los_mute_strap(strap), .i_rx_update_edge_select(edge_sel), .i_tx_edge_strap(tx_edge),
      .i_ext_resistor_select(res), .i_termination_select(term), .i_rec_clk(rec),
      .i_loss_detect(loss), .i_rx_valid(valid), .o_rx_ready(ready), .i_rx_pos_data(pos),
      .i_rx_neg_data(neg), .o_rx_pos_rail_out(rp), .o_rx_neg_rail_out(rn),
      .o_loss_of_signal_flag(flag), .o_ext_resistor_select(ext), .o_int_impedance_adjust(imp),
      .o_termination_select(tsel), .o_host_bus_type_select(bus), .i_addr(addr),
      .i_wr_data(wdata), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata));

   rsc_framer_model partner (.i_core_clk(i_core_clk), .i_rec_clk(rec), .i_edge_sel(edge_sel),
      .i_mute_en(mute_en), .i_pos(rp), .i_neg(rn), .o_los_mute_strap(strap), .o_cap(cap));

   initial begin
      i_core_clk = 1'b0;
      forever #12.5 i_core_clk = ~i_core_clk;
   end

   // ==========================================================
   // Shared tasks
   task stop_test();
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : tick

   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_core_clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge i_core_clk) wr <= 1'b0;
   endtask : wr_reg

   task rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_core_clk) begin addr <= a; rd <= 1'b1; end
      @(posedge i_core_clk) rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, exp}, "read data");
   endtask : rd_chk

   // Ready is looked at inside the cycle whose closing edge takes the word
   task push(input logic [15:0] w);
      @(posedge i_core_clk) begin valid <= 1'b1; pos <= w[7:0]; neg <= w[15:8]; end
      #1 chk({15'h0000, ready}, 16'h0001, "ready at push");
      @(posedge i_core_clk) valid <= 1'b0;
   endtask : push

   // Recovered clock is slow; several core cycles per phase
   task rc(input logic v);
      @(posedge i_core_clk) rec <= v;
      tick(6);
   endtask : rc

   // ==========================================================
   // Scenarios
   task t_reset();
      chk({rn, rp}, 16'h0000, "rails after reset");
      chk({15'h0000, ready}, 16'h0001, "ready after reset");
      rd_chk(4'h0, 8'h04);
      rd_chk(4'h9, 8'h00);
      wr_reg(4'hF, 8'hFF);
      rd_chk(4'hF, 8'h00);
   endtask : t_reset

   task t_res();
      for (int c = 0; c < 4; c++) begin
         @(posedge i_core_clk) begin res <= c[1:0]; term <= ~c[1:0]; end
         tick(3);
         chk(ext, {8{c[1:0]}}, "resistor code");
         chk({8'h00, imp}, {8'h00, {8{c != 0}}}, "impedance adjust");
         chk(tsel, {8{~c[1:0]}}, "termination code");
      end
   endtask : t_res

   task t_host();
      @(posedge i_core_clk) begin host <= 1'b1; res <= 2'b11; end
      for (int b = 0; b < 4; b++) begin
         @(posedge i_core_clk) begin tx_edge <= b[1]; edge_sel <= b[0]; end
         tick(3);
         chk({14'h0000, bus}, {14'h0000, b[1:0]}, "bus type");
      end
      @(posedge i_core_clk) begin tx_edge <= 1'b0; edge_sel <= 1'b0; end
      wr_reg(4'h3, 8'h06);
      tick(3);
      chk(ext, 16'h0080, "host resistor code");
      rd_chk(4'h3, 8'h16);
      @(posedge i_core_clk) begin host <= 1'b0; res <= 2'b00; end
      tick(3);
      chk({14'h0000, bus}, 16'h0000, "bus type in hardware mode");
   endtask : t_host

   // Update edge leaves level s; the opposite edge must not move the rails
   task t_edge(input logic s, input logic [15:0] w1, input logic [15:0] w2);
      @(posedge i_core_clk) edge_sel <= s;
      rc(s);
      push(w1);
      rc(~s);
      chk({rn, rp}, w1, "rails on update edge");
      push(w2);
      rc(s);
      chk({rn, rp}, w1, "rails on other edge");
      chk(cap, w1, "framer capture");
      rc(~s);
      chk({rn, rp}, w2, "rails on next update");
   endtask : t_edge

   task t_fifo();
      @(posedge i_core_clk) edge_sel <= 1'b0;
      rc(1'b0);
      wr_reg(4'h9, 8'h08);
      rd_chk(4'h9, 8'h00);
      for (int i = 0; i < 16; i++) push({4{i[3:0]}});
      tick(2);
      chk({15'h0000, ready}, 16'h0000, "ready when full");
      for (int i = 0; i < 16; i++) begin
         rc(1'b1);
         chk({rn, rp}, {4{i[3:0]}}, "drained word");
         rc(1'b0);
      end
      rc(1'b1);
      chk({rn, rp}, 16'hFFFF, "rails hold on empty");
      rd_chk(4'h9, 8'h08);
      wr_reg(4'h9, 8'h08);
      rd_chk(4'h9, 8'h00);
   endtask : t_fifo

   task t_mute();
      @(posedge i_core_clk) begin mute_en <= 1'b1; loss <= 8'h01; end
      tick(3);
      chk({8'h00, flag}, 16'h0001, "loss flag");
      chk({rn, rp}, 16'hFEFE, "muted channel only");
      rd_chk(4'h8, 8'h01);
      @(posedge i_core_clk) loss <= 8'h00;
      tick(3);
      chk({8'h00, flag}, 16'h0001, "flag held for a clock");
      rc(1'b0);
      rc(1'b1);
      chk({8'h00, flag}, 16'h0000, "flag cleared");
      push(16'hF00F);
      rc(1'b0);
      rc(1'b1);
      chk({rn, rp}, 16'hF00F, "data back after loss");
   endtask : t_mute

   task t_nomute();
      @(posedge i_core_clk) begin mute_en <= 1'b0; loss <= 8'hFF; end
      tick(3);
      chk({8'h00, flag}, 16'h00FF, "loss flags all");
      chk({rn, rp}, 16'hF00F, "rails not muted");
      push(16'h3CC3);
      rc(1'b0);
      rc(1'b1);
      chk({rn, rp}, 16'h3CC3, "data passes in loss");
      @(posedge i_core_clk) loss <= 8'h00;
   endtask : t_nomute

   // ==========================================================
   // Main sequence
   initial begin
      error_cnt = 0;
      checks = 0;
      {i_rstn, host, edge_sel, tx_edge, rec, valid, wr, rd} = '0;
      {res, term, loss, pos, neg, wdata, addr} = '0;
      mute_en = 1'b1;
      repeat (3) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      tick(1);
      t_reset();
      t_res();
      t_host();
      t_edge(1'b0, 16'hA55A, 16'h1234);
      t_edge(1'b1, 16'h5AA5, 16'h4321);
      t_fifo();
      t_mute();
      t_nomute();
      stop_test();
   end
endmodule : rx_output_strap_control_tb_top

`default_nettype wire
